// ---- design/pin_select_regs.vh ----
// register offsets, field positions, reset values for the pin select block
`ifndef PIN_SELECT_REGS_VH
`define PIN_SELECT_REGS_VH

// register word offsets (byte addresses)
`define ADDR_CLK_CTRL     8'h00
`define ADDR_SERIAL_CTRL  8'h04
`define ADDR_PULSE_CTRL   8'h08
`define ADDR_CC_CTRL      8'h0C
`define ADDR_PORT_DIR     8'h10
`define ADDR_PORT_LATCH   8'h14
`define ADDR_PIN_STATUS   8'h18

// clock control fields
`define CLK_MAIN_SUB_SEL  0
`define CLK_SUB_STOP      1
`define CLK_SUB_PORT_SW   2
`define CLK_MAIN_STOP     3
`define CLK_ALL_STOP      4
`define CLK_MAIN_FB_DIS   5
`define CLK_SUB_FB_DIS    6
`define CLK_MAIN_PORT_SW  7
`define CLK_CTRL_RESET    8'h08

// serial control fields
`define SER_RX_SEL_LO     0
`define SER_MODE_LO       2
`define SER_I2C_BIT       5
`define SER_RX_SEL_I2C    2'h3
`define SER_MODE_I2C      3'h2
`define SER_CTRL_RESET    8'h00

// pulse timer control fields
`define PT_MODE_LO        0
`define PT_TOGGLE         2
`define PULSE_CTRL_RESET  8'h00

// capture/compare control: out disable a..d at 3:0, dual pwm bit at 4,
// pwm b..d at 7:5, trigger edge at 9:8, io ctrl a..d at 21:10
`define CC_OUT_DIS_LO     0
`define CC_DUAL_PWM       4
`define CC_PWM_LO         5
`define CC_TRIG_EDGE_LO   8
`define CC_IO_CTRL_LO     10
`define CC_OUT_DIS_RESET  4'hF
`define CC_DUAL_PWM_RESET 1'b1

// pin mode codes per pin; the status word does not report them
`define MODE_GPIO_IN      3'h0
`define MODE_GPIO_OUT     3'h1
`define MODE_PERIPH_OUT   3'h2
`define MODE_PERIPH_IN    3'h3
`define MODE_OSC          3'h4
`define MODE_I2C          3'h5

`endif

// ---- design/osc_pin_ctrl.v ----
// oscillator pin control for the main and sub clock pins
`timescale 1ns/1ps
module osc_pin_ctrl (
	// clock control bits
	input  wire main_sub_pin_select,
	input  wire sub_clock_stop,
	input  wire sub_port_switch,
	input  wire main_clock_stop,
	input  wire all_clock_stop,
	input  wire main_feedback_disable,
	input  wire sub_feedback_disable,
	input  wire main_port_switch,
	// oscillator circuit controls
	output reg  main_buf_en,
	output reg  main_fb_en,
	output reg  sub_buf_en,
	output reg  sub_fb_en,
	output wire osc_owns_pins
);

	wire main_mode;
	wire sub_mode;

	// pin mode decode
	assign main_mode = ~main_sub_pin_select & main_port_switch;
	assign sub_mode  = main_sub_pin_select & sub_port_switch &
		main_port_switch;
	assign osc_owns_pins = main_mode | sub_mode;

	// buffer and feedback resistor enables
	always @* begin
		main_buf_en = 1'b0;
		main_fb_en  = 1'b0;
		sub_buf_en  = 1'b0;
		sub_fb_en   = 1'b0;
		if (all_clock_stop) begin
			main_buf_en = 1'b0; // RULE6
		end else if (main_mode) begin
			main_buf_en = ~main_clock_stop; // RULE1 RULE2 RULE3
			main_fb_en  = ~main_feedback_disable; // RULE1 RULE2 RULE3
		end else if (sub_mode) begin
			sub_buf_en = ~sub_clock_stop; // RULE4 RULE5
			sub_fb_en  = ~sub_feedback_disable; // RULE4 RULE5
		end
	end

endmodule // osc_pin_ctrl

// ---- design/cc_pin_decode.v ----
// capture/compare timer pin mode decode for one channel
`timescale 1ns/1ps
module cc_pin_decode (
	// channel control
	input  wire       out_disable,
	input  wire       dual_pwm_mode_bit,
	input  wire       pwm_mode,
	input  wire [2:0] io_ctrl,
	input  wire [1:0] trig_edge,
	input  wire       is_chan_a,
	// decoded pin use
	output reg        drive_out,
	output reg        capture_in,
	output reg        trigger_in
);

	// channel mode decode
	always @* begin
		drive_out  = 1'b0;
		capture_in = 1'b0;
		trigger_in = 1'b0;
		if (!dual_pwm_mode_bit) begin
			if (is_chan_a) begin
				trigger_in = out_disable & (trig_edge != 2'b00); // RULE9
			end else begin
				drive_out = ~out_disable; // RULE10
			end
		end else if (pwm_mode && !is_chan_a) begin
			drive_out = ~out_disable; // RULE11
		end else if (io_ctrl[2]) begin
			capture_in = 1'b1; // RULE13
		end else begin
			drive_out = ~out_disable & (io_ctrl[1:0] != 2'b00); // RULE12
		end
	end

endmodule // cc_pin_decode

// ---- design/osc_and_timer_pin_select.v ----
// shared port pin function select with its control register file
//
// Operation
// RULE1: main pin mode with no stops enables the main buffer, feedback when its disable bit is low.
// RULE2: main pin mode, clock running, feedback disable high keeps buffer on and resistor off.
// RULE3: main pin mode with main stop high turns the buffer off; resistor follows its disable bit.
// RULE4: sub pin mode with no stops runs the sub buffer, resistor following its disable bit.
// RULE5: sub pin mode with sub stop high turns the sub buffer off; resistor still follows its bit.
// RULE6: all-clock-stop forces both buffers and both resistors off.
// RULE7: the shared pin is the serial i2c clock only with dir 0, rx select 11b, mode 010, i2c bit 1.
// RULE8: pulse timer pin mode decodes pulse, programmable, one-shot and wait one-shot outputs.
// RULE9: channel a is the dual pwm trigger input when disabled, dual pwm selected and edge nonzero.
// RULE10: channel b drives the dual pwm wave when enabled and dual pwm selected.
// RULE11: channels b to d drive the pwm wave when enabled in pwm mode.
// RULE12: in timer mode an enabled channel with io field 001 or 01x drives the compare output.
// RULE13: in timer mode an io field with its top bit set makes the pin a capture input.
// RULE14: an unclaimed pin is a general input or, with its direction bit set, a latch output.
// RULE15: all control bits reset to defaults that leave every shared pin a general input.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pin_select_regs.vh"
module osc_and_timer_pin_select (
	// clock and reset
	input  wire        core_clk,
	input  wire        sys_rst,
	// register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// oscillator circuit controls
	output wire        main_buf_en,
	output wire        main_fb_en,
	output wire        sub_buf_en,
	output wire        sub_fb_en,
	// peripheral sources
	input  wire        serial_scl_out,
	input  wire        pulse_timer_wave,
	input  wire [3:0]  cc_wave,
	// pin 45: serial i2c clock or gpio
	input  wire        pin45_in,
	output reg         pin45_out,
	output reg         pin45_oe,
	output wire        serial_scl_in,
	// pins 46 and 47: oscillator or gpio
	input  wire        pin46_in,
	output reg         pin46_out,
	output reg         pin46_oe,
	input  wire        pin47_in,
	output reg         pin47_out,
	output reg         pin47_oe,
	// pulse timer pin
	output reg         pulse_timer_out_pin,
	output reg         pulse_timer_out_oe,
	output reg  [1:0]  pulse_timer_kind,
	// capture/compare pins a..d
	input  wire [3:0]  cc_pin_in,
	output reg  [3:0]  cc_pin_out,
	output reg  [3:0]  cc_pin_oe,
	output wire [3:0]  cc_capture_en,
	output wire        dual_pwm_trigger,
	// input samples for gpio
	output wire [2:0]  gpio_in
);

	////////////////////////////////////////////////////////////////////
	// control registers

	reg  [7:0]  clk_ctrl_ff;
	reg  [7:0]  ser_ctrl_ff;
	reg  [7:0]  pulse_ctrl_ff;
	reg  [21:0] cc_ctrl_ff;
	reg  [2:0]  port_dir_ff;
	reg  [2:0]  port_latch_ff;
	reg  [31:0] nxt_reg_rdata;
	wire [31:0] pin_status;
	wire        osc_owns_pins;
	wire        i2c_clk_sel;
	wire [3:0]  cc_drive;
	wire [3:0]  cc_trig;
	wire        pulse_active;

	// register writes, defaults leave pins as inputs
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_ctrl_ff   <= `CLK_CTRL_RESET; // RULE15
			ser_ctrl_ff   <= `SER_CTRL_RESET; // RULE15
			pulse_ctrl_ff <= `PULSE_CTRL_RESET; // RULE15
			cc_ctrl_ff    <= {18'h0_0000, `CC_OUT_DIS_RESET}; // RULE15
			port_dir_ff   <= 3'h0; // RULE15
			port_latch_ff <= 3'h0;
		end else if (reg_wr) begin
			if (reg_addr == `ADDR_CLK_CTRL) begin
				clk_ctrl_ff <= reg_wdata[7:0];
			end else if (reg_addr == `ADDR_SERIAL_CTRL) begin
				ser_ctrl_ff <= reg_wdata[7:0];
			end else if (reg_addr == `ADDR_PULSE_CTRL) begin
				pulse_ctrl_ff <= reg_wdata[7:0];
			end else if (reg_addr == `ADDR_CC_CTRL) begin
				cc_ctrl_ff <= reg_wdata[21:0];
			end else if (reg_addr == `ADDR_PORT_DIR) begin
				port_dir_ff <= reg_wdata[2:0];
			end else if (reg_addr == `ADDR_PORT_LATCH) begin
				port_latch_ff <= reg_wdata[2:0];
			end
		end
	end

	// read mux, unmapped addresses read zero
	always @* begin
		nxt_reg_rdata = 32'h0000_0000;
		if (!reg_rd) begin
			nxt_reg_rdata = 32'h0000_0000;
		end else if (reg_addr == `ADDR_CLK_CTRL) begin
			nxt_reg_rdata = {24'h00_0000, clk_ctrl_ff};
		end else if (reg_addr == `ADDR_SERIAL_CTRL) begin
			nxt_reg_rdata = {24'h00_0000, ser_ctrl_ff};
		end else if (reg_addr == `ADDR_PULSE_CTRL) begin
			nxt_reg_rdata = {24'h00_0000, pulse_ctrl_ff};
		end else if (reg_addr == `ADDR_CC_CTRL) begin
			nxt_reg_rdata = {10'h000, cc_ctrl_ff};
		end else if (reg_addr == `ADDR_PORT_DIR) begin
			nxt_reg_rdata = {29'h0000_0000, port_dir_ff};
		end else if (reg_addr == `ADDR_PORT_LATCH) begin
			nxt_reg_rdata = {29'h0000_0000, port_latch_ff};
		end else if (reg_addr == `ADDR_PIN_STATUS) begin
			nxt_reg_rdata = pin_status;
		end
	end

	// read data register, valid the cycle after the strobe only
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= nxt_reg_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// oscillator pins

	osc_pin_ctrl u_osc (
		.main_sub_pin_select  (clk_ctrl_ff[`CLK_MAIN_SUB_SEL]),
		.sub_clock_stop       (clk_ctrl_ff[`CLK_SUB_STOP]),
		.sub_port_switch      (clk_ctrl_ff[`CLK_SUB_PORT_SW]),
		.main_clock_stop      (clk_ctrl_ff[`CLK_MAIN_STOP]),
		.all_clock_stop       (clk_ctrl_ff[`CLK_ALL_STOP]),
		.main_feedback_disable(clk_ctrl_ff[`CLK_MAIN_FB_DIS]),
		.sub_feedback_disable (clk_ctrl_ff[`CLK_SUB_FB_DIS]),
		.main_port_switch     (clk_ctrl_ff[`CLK_MAIN_PORT_SW]),
		.main_buf_en          (main_buf_en),
		.main_fb_en           (main_fb_en),
		.sub_buf_en           (sub_buf_en),
		.sub_fb_en            (sub_fb_en),
		.osc_owns_pins        (osc_owns_pins)
	);

	// oscillator pins released to gpio when no oscillator mode is set
	always @* begin
		pin46_out = port_latch_ff[1];
		pin46_oe  = port_dir_ff[1] & ~osc_owns_pins; // RULE14
		pin47_out = port_latch_ff[2];
		pin47_oe  = port_dir_ff[2] & ~osc_owns_pins; // RULE14
	end

	////////////////////////////////////////////////////////////////////
	// serial i2c clock pin

	assign i2c_clk_sel = ~port_dir_ff[0] &
		(ser_ctrl_ff[`SER_RX_SEL_LO+1:`SER_RX_SEL_LO] ==
		`SER_RX_SEL_I2C) &
		(ser_ctrl_ff[`SER_MODE_LO+2:`SER_MODE_LO] == `SER_MODE_I2C) &
		ser_ctrl_ff[`SER_I2C_BIT]; // RULE7

	// open-drain clock when selected, else port latch
	always @* begin
		if (i2c_clk_sel) begin
			pin45_out = 1'b0;
			pin45_oe  = ~serial_scl_out; // RULE7
		end else begin
			pin45_out = port_latch_ff[0];
			pin45_oe  = port_dir_ff[0]; // RULE14
		end
	end

	assign serial_scl_in = i2c_clk_sel ? pin45_in : 1'b1;
	assign gpio_in       = {pin47_in, pin46_in, pin45_in};

	////////////////////////////////////////////////////////////////////
	// pulse timer pin

	// kind: 0 pulse, 1 programmable, 2 one-shot, 3 wait one-shot
	assign pulse_active = (pulse_ctrl_ff[`PT_MODE_LO+1:`PT_MODE_LO]
		!= 2'b00);

	always @* begin
		pulse_timer_kind    = 2'b00;
		pulse_timer_out_pin = pulse_timer_wave;
		pulse_timer_out_oe  = pulse_active;
		case (pulse_ctrl_ff[`PT_MODE_LO+1:`PT_MODE_LO])
		2'b01: begin
			pulse_timer_kind = pulse_ctrl_ff[`PT_TOGGLE] ?
				2'b01 : 2'b00; // RULE8
		end
		2'b10: begin
			pulse_timer_kind = 2'b10; // RULE8
		end
		2'b11: begin
			pulse_timer_kind = 2'b11; // RULE8
		end
		default: begin
			pulse_timer_kind = 2'b00;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// capture/compare channels

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1) begin : g_cc
			cc_pin_decode u_dec (
				// c and d have no dual pwm use: hold them off there
				.out_disable      (cc_ctrl_ff[`CC_OUT_DIS_LO+ch] |
					((ch >= 2) & ~cc_ctrl_ff[`CC_DUAL_PWM])), // RULE10
				.dual_pwm_mode_bit(cc_ctrl_ff[`CC_DUAL_PWM]),
				.pwm_mode         ((ch == 0) ? 1'b0 :
					cc_ctrl_ff[`CC_PWM_LO+ch-1]),
				.io_ctrl          (cc_ctrl_ff[`CC_IO_CTRL_LO+3*ch+2:
					`CC_IO_CTRL_LO+3*ch]),
				.trig_edge        (cc_ctrl_ff[`CC_TRIG_EDGE_LO+1:
					`CC_TRIG_EDGE_LO]),
				.is_chan_a        ((ch == 0) ? 1'b1 : 1'b0),
				.drive_out        (cc_drive[ch]),
				.capture_in       (cc_capture_en[ch]),
				.trigger_in       (cc_trig[ch])
			);
		end
	endgenerate

	// channel pin drive
	always @* begin
		cc_pin_out = cc_wave;
		cc_pin_oe  = cc_drive;
	end

	assign dual_pwm_trigger = cc_trig[0] & cc_pin_in[0]; // RULE9

	// pin status word
	assign pin_status = {14'h0000, cc_capture_en, cc_drive, cc_trig[0],
		pulse_timer_kind, pulse_active, i2c_clk_sel, osc_owns_pins,
		sub_buf_en, sub_fb_en, main_buf_en, main_fb_en};

endmodule // osc_and_timer_pin_select

// ---- verif/pin_select_props.sv ----
// checker for the oscillator enables of the pin select block
`timescale 1ns/1ps
`include "pin_select_regs.vh"
module pin_select_props (
	// clock, reset and register writes
	input wire        core_clk,
	input wire        sys_rst,
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	// oscillator enables and pin samples
	input wire        main_buf_en,
	input wire        main_fb_en,
	input wire        sub_buf_en,
	input wire        sub_fb_en,
	input wire        pin45_in,
	input wire        pin46_in,
	input wire        pin47_in,
	input wire [2:0]  gpio_in
);
	reg  [7:0] clk_ff;
	wire       mm = !clk_ff[0] && clk_ff[7];
	wire       sm = clk_ff[0] && clk_ff[2] && clk_ff[7];
	wire       st = clk_ff[4];
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// shadow of the clock control register, lands with the write edge
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			clk_ff <= `CLK_CTRL_RESET;
		else if (reg_wr && reg_addr == `ADDR_CLK_CTRL)
			clk_ff <= reg_wdata[7:0];
	end
	property p_main_run;
		mm && !st && !clk_ff[3] |-> main_buf_en;
	endproperty
	a_main_run: assert property (p_main_run)
		else $error("main buffer off while running");
	property p_main_fb;
		mm && !st |-> main_fb_en == !clk_ff[5];
	endproperty
	a_main_fb: assert property (p_main_fb)
		else $error("main feedback wrong");
	property p_main_stop;
		mm && clk_ff[3] |-> !main_buf_en;
	endproperty
	a_main_stop: assert property (p_main_stop)
		else $error("main buffer on while stopped");
	property p_sub_run;
		sm && !st && !clk_ff[1] |-> sub_buf_en;
	endproperty
	a_sub_run: assert property (p_sub_run)
		else $error("sub buffer off while running");
	property p_sub_fb;
		sm && !st |-> sub_fb_en == !clk_ff[6];
	endproperty
	a_sub_fb: assert property (p_sub_fb)
		else $error("sub feedback wrong");
	property p_sub_stop;
		sm && clk_ff[1] |-> !sub_buf_en;
	endproperty
	a_sub_stop: assert property (p_sub_stop)
		else $error("sub buffer on while stopped");
	property p_stop_wr;
		reg_wr && reg_addr == `ADDR_CLK_CTRL && reg_wdata[4] |=>
			!(main_buf_en || main_fb_en || sub_buf_en || sub_fb_en);
	endproperty
	a_stop_wr: assert property (p_stop_wr)
		else $error("oscillator left on in stop");
	property p_gpio;
		gpio_in == {pin47_in, pin46_in, pin45_in};
	endproperty
	a_gpio: assert property (p_gpio)
		else $error("pin sample mismatch");
	c_main: cover property (main_buf_en && main_fb_en);
	c_sub: cover property (sub_buf_en && !sub_fb_en);
	c_stop: cover property (st && mm);
endmodule // pin_select_props

bind osc_and_timer_pin_select pin_select_props u_props (.core_clk,
	.sys_rst, .reg_addr, .reg_wdata, .reg_wr, .main_buf_en, .main_fb_en,
	.sub_buf_en, .sub_fb_en, .pin45_in, .pin46_in, .pin47_in, .gpio_in);

// ---- verif/osc_pin_world.sv ----
// far-side model: board pin levels and peripheral waveforms
`timescale 1ns/1ps
module osc_pin_world (
	// clock
	input  wire       core_clk,
	// board levels and device drives, pins 45..47 then a..d
	input  wire [6:0] ext_lvl,
	input  wire [6:0] pin_out,
	input  wire [6:0] pin_oe,
	// sensed levels and peripheral sources
	output wire [6:0] pin_in,
	output reg  [5:0] wave_ff
);
	// a driven pin shows the device level, an undriven one the board
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	// peripheral waveforms keep moving so a stuck path shows
	initial wave_ff = 6'h00;
	always @(posedge core_clk) begin
		wave_ff <= wave_ff + 6'h01;
	end
endmodule // osc_pin_world

// ---- verif/osc_and_timer_pin_select_tb.sv ----
// self-checking bench for the shared pin select block
`timescale 1ns/1ps
`include "pin_select_regs.vh"
module osc_and_timer_pin_select_tb;
	typedef struct {string nm; logic [31:0] m; logic [31:0] e;} note_t;
	logic        core_clk, sys_rst, reg_wr, reg_rd, rd_d;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [6:0]  ext_lvl;
	logic [63:0] x;
	logic [15:0] lfsr;
	wire  [6:0]  p_out, p_oe, p_in;
	wire  [5:0]  wave;
	wire  [3:0]  cap;
	wire  [2:0]  gpio_in;
	wire  [1:0]  pt_kind;
	wire         mbe, mfe, sbe, sfe, scl_in, pt_pin, pt_oe, trg;
	note_t       q[$];
	note_t       n;
	int          n_fail = 0, checks_done = 0, cyc = 0;
	osc_and_timer_pin_select dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_buf_en(mbe),
		.main_fb_en(mfe), .sub_buf_en(sbe), .sub_fb_en(sfe),
		.serial_scl_out(wave[0]), .pulse_timer_wave(wave[1]),
		.cc_wave(wave[5:2]), .pin45_in(p_in[0]), .pin45_out(p_out[0]),
		.pin45_oe(p_oe[0]), .serial_scl_in(scl_in), .pin46_in(p_in[1]),
		.pin46_out(p_out[1]), .pin46_oe(p_oe[1]), .pin47_in(p_in[2]),
		.pin47_out(p_out[2]), .pin47_oe(p_oe[2]),
		.pulse_timer_out_pin(pt_pin), .pulse_timer_out_oe(pt_oe),
		.pulse_timer_kind(pt_kind), .cc_pin_in(p_in[6:3]),
		.cc_pin_out(p_out[6:3]), .cc_pin_oe(p_oe[6:3]),
		.cc_capture_en(cap), .dual_pwm_trigger(trg), .gpio_in(gpio_in));
	osc_pin_world u_world (.core_clk(core_clk), .ext_lvl(ext_lvl),
		.pin_out(p_out), .pin_oe(p_oe), .pin_in(p_in), .wave_ff(wave));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	function automatic [15:0] nx(input [15:0] s);
		nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// status mask and value for a clock control setting
	function automatic [63:0] e_clk(input [7:0] c);
		if (c[4] || !(c[7] || c[2]))
			e_clk = {32'h0000_000F, 32'h0000_0000};
		else if (!c[0] && c[7])
			e_clk = {32'h0000_0003, 30'h0, !c[3], !c[5]};
		else if (c[0] && c[2] && c[7])
			e_clk = {32'h0000_000C, 28'h0, !c[1], !c[6], 2'h0};
		else
			e_clk = 64'h0;
	endfunction
	// status mask and value for a capture/compare setting
	function automatic [63:0] e_cc(input [31:0] v);
		logic [31:0] m;
		logic [31:0] e;
		logic [2:0]  io;
		m = 32'h0;
		e = {22'h0, !v[4] && v[0] && (v[9] || v[8]), 9'h0};
		m[9] = v[4] || v[0];
		if (!v[4]) begin
			m[13:10] = 4'hF;
			e[11] = !v[1];
		end
		for (int i = 0; i < 4 && v[4]; i++) begin
			io = v[10 + 3 * i +: 3];
			m[10 + i] = 1'b1;
			m[14 + i] = 1'b1;
			if (i > 0 && v[4 + i])
				e[10 + i] = !v[i];
			else begin
				e[10 + i] = !v[i] && !io[2] && (io[1] || io[0]);
				e[14 + i] = io[2];
			end
		end
		e_cc = {m, e};
	endfunction
	task automatic wr(input [7:0] a, input [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input [7:0] a, input string s, input [31:0] m, e);
		q.push_back('{s, m, e});
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic chk(input string s, input [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// read results land one cycle after the strobe
	always @(posedge core_clk) begin
		rd_d <= reg_rd;
		cyc++;
		if (rd_d && q.size() > 0) begin
			n = q.pop_front();
			chk(n.nm, reg_rdata & n.m, n.e & n.m);
		end
		if (cyc == 6000) begin
			n_fail++;
			report_and_stop();
		end
	end
	// main sequence
	initial begin
		{sys_rst, reg_wr, reg_rd} = 3'h4;
		{reg_addr, reg_wdata, ext_lvl} = 47'h0;
		lfsr = 16'h000E;
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(`ADDR_CLK_CTRL, "clk", 32'hFFFF_FFFF, 32'h0000_0008);
		rd(`ADDR_CC_CTRL, "cc", 32'hFFFF_FFFF, 32'h0000_000F);
		rd(8'h1C, "hole", 32'hFFFF_FFFF, 32'h0000_0000);
		chk("oe", {25'h0, p_oe}, 32'h0);
		$display("test reset done");
		for (int c = 0; c < 256; c++) begin
			wr(`ADDR_CLK_CTRL, 32'(c));
			x = e_clk(c[7:0]);
			rd(`ADDR_PIN_STATUS, "osc", x[63:32], x[31:0]);
		end
		$display("test clock done");
		wr(`ADDR_CLK_CTRL, 32'h0);
		wr(`ADDR_PORT_DIR, 32'h7);
		wr(`ADDR_PORT_LATCH, 32'h5);
		@(negedge core_clk);
		chk("gpio out", {26'h0, p_oe[2:0], p_out[2:0]}, 32'h3D);
		wr(`ADDR_PORT_DIR, 32'h0);
		for (int s = 0; s < 65; s++) begin
			wr(`ADDR_SERIAL_CTRL, s == 64 ? 32'h2B : 32'(s));
			if (s == 64)
				wr(`ADDR_PORT_DIR, 32'h1);
			rd(`ADDR_PIN_STATUS, "i2c", 32'h20, s == 43 ? 32'h20 : 32'h0);
		end
		wr(`ADDR_PORT_DIR, 32'h0);
		@(negedge core_clk);
		chk("scl", {p_oe[0], p_out[0], scl_in}, {!wave[0], 1'b0, p_in[0]});
		$display("test serial done");
		for (int p = 0; p < 8; p++) begin
			wr(`ADDR_PULSE_CTRL, 32'(p));
			v = p[1:0] == 2'h1 ? {p[2], 1'b1} : {p[1:0], p[1:0] != 0};
			rd(`ADDR_PIN_STATUS, "pulse", p[1:0] ? 32'h1C0 : 32'h40, v << 6);
		end
		$display("test pulse done");
		// release the i2c clock so pin 45 shows the board level again
		wr(`ADDR_SERIAL_CTRL, 32'h0);
		for (int k = 0; k < 64; k++) begin
			lfsr = nx(lfsr);
			v = {lfsr, nx(lfsr)};
			lfsr = nx(lfsr);
			ext_lvl <= v[31:25];
			wr(`ADDR_CC_CTRL, v);
			x = e_cc(v);
			rd(`ADDR_PIN_STATUS, "cc", x[63:32], x[31:0]);
			chk("pins in", {29'h0, gpio_in}, {29'h0, ext_lvl[2:0]});
			chk("trigger", {31'h0, trg}, {31'h0, x[9] & ext_lvl[3]});
		end
		$display("test timer done");
		repeat (3) @(posedge core_clk);
		report_and_stop();
	end
endmodule // osc_and_timer_pin_select_tb
